/* logic/eba_bulk_access.sv */
/*
  Bulk programming gate for the nonvolatile configuration store:
  key sequencer, erase control, auto-incrementing word port, busy
  status and command refusal. Assumes an SMBus front end on the same
  clock that presents one decoded command per cmd_valid pulse, checks
  PEC on incoming writes, appends PEC on reads when pec_required is
  high, and turns rsp.nack into a NACK on the wire.
*/
//
// Contract
// - 0x2B,0xD4 unlocks read/write, PEC optional
// - 0x2B,0xD5 unlocks read/write, PEC required
// - 0x2B,0x91,0xE4 read-only all space, PEC optional
// - 0x2B,0x91,0xE5 read-only all space, PEC required
// - Any other key sequence locks
// - Key readback: last byte, zero when locked
// - Completed unlock clears word pointer
// - Erase key 0x2B erases; other values lock
// - Erase readback returns last written value
// - First read returns packing revision id
// - Second read returns available word count
// - Later reads stream words from lowest address
// - Read past end returns zero, locks
// - Writes fill from lowest; overflow write locks
// - Transfers bypass working configuration
// - Busy clears not-busy status flag
// - Status byte read is never refused
// - Busy refuses every other command
// - Bulk erase holds busy about 400 ms
// - PEC optional or mandatory per mode
// - Commands 0xBD,0xBE byte; 0xBF word
`timescale 1ns/1ps
`include "eba_map.svh"
module eba_bulk_access
  import eba_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `EBA_ERASE_CYC,
  parameter int unsigned PROG_CYCLES = `EBA_PROG_CYC
) (
  input wire logic clk, // Core clock, 10 MHz
  input wire logic sys_rst, // Sync reset, high
  input wire logic cmd_valid, // One-cycle command strobe
  input wire eba_cmd_t cmd, // Decoded command
  output logic rsp_valid, // Answer strobe
  output eba_rsp_t rsp, // Answer: nack and read data
  output logic pec_required, // Current mode demands PEC
  output logic [7:0] status_byte, // Common status byte
  output eba_mode_t mode, // Current access mode
  output logic busy // Store operation running
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [15:0] USER_CNT = 16'(`EBA_USER_WORDS);
  localparam logic [15:0] FULL_CNT =
    16'(`EBA_USER_WORDS + `EBA_MFR_WORDS);

  logic is_key, is_erase, is_data, is_stat, ours;
  logic req_pec, pec_bad, refuse, take;
  logic key_wr, ers_wr, dat_wr, dat_rd;
  logic rw_mode, ro_mode, seq_done, nvm_busy;
  logic erase_go, prog_go, ers_lock, wr_lock, rd_lock, rd_over;
  logic rd_adv, lock_req;
  logic [15:0] word_count, rd_idx, rd_word, mfr_word, nvm_word;
  logic [15:0] ptr_r, ans_data;
  logic [7:0] last_key_r, ers_val_r;
  logic erased_r, rsp_valid_r;
  eba_rsp_t rsp_r;
  eba_dir_t dir_r;
  eba_mode_t mode_w;

  ////////////////////////////////////////////////////////////////////////
  // Command decode and refusal

  always_comb begin
    is_key = (cmd.code == `EBA_CMD_UNLOCK);
    is_erase = (cmd.code == `EBA_CMD_ERASE);
    is_data = (cmd.code == `EBA_CMD_DATA);
    is_stat = (cmd.code == `EBA_CMD_STATUS) && !cmd.write;
    ours = is_key || is_erase || is_data;
  end

  assign req_pec = (mode_w == EBA_RW_REQ) || (mode_w == EBA_RO_REQ);
  assign pec_required = req_pec;

  // A PEC byte is always checked when sent; only the strict modes
  // insist that it is sent at all
  assign pec_bad = cmd.write &&
    ((req_pec && !cmd.pec_present) ||
     (cmd.pec_present && !cmd.pec_ok));

  // The status read wins over everything, so a host can always poll
  assign refuse = is_stat ? 1'b0 :
    (nvm_busy || (ours && pec_bad));
  assign take = cmd_valid && !refuse;

  assign key_wr = take && cmd.write && is_key;
  assign ers_wr = take && cmd.write && is_erase;
  assign dat_wr = take && cmd.write && is_data;
  assign dat_rd = take && !cmd.write && is_data;

  assign rw_mode = (mode_w == EBA_RW_OPT) || (mode_w == EBA_RW_REQ);
  assign ro_mode = (mode_w == EBA_RO_OPT) || (mode_w == EBA_RO_REQ);

  ////////////////////////////////////////////////////////////////////////
  // Key sequencer

  eba_unlock u_unlock (
    .clk(clk),
    .sys_rst(sys_rst),
    .key_wr(key_wr),
    .key_byte(cmd.wdata[7:0]),
    .lock_req(lock_req),
    .mode(mode_w),
    .seq_done(seq_done)
  );

  assign mode = mode_w;

  always_ff @(posedge clk) begin
    if (sys_rst) last_key_r <= `EBA_BYTE_RST;
    else if (key_wr) last_key_r <= cmd.wdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Erase control

  // Only a read/write mode may erase; a wrong value or a read-only
  // mode throws the part back to locked
  assign erase_go = ers_wr && rw_mode &&
    (cmd.wdata[7:0] == `EBA_ERASE_KEY);
  assign ers_lock = ers_wr && (mode_w != EBA_LOCKED) &&
    (ro_mode || cmd.wdata[7:0] != `EBA_ERASE_KEY);

  always_ff @(posedge clk) begin
    if (sys_rst) ers_val_r <= `EBA_BYTE_RST;
    else if (ers_wr) ers_val_r <= cmd.wdata[7:0];
  end

  // Writes are only allowed after an erase; a full pass
  // uses the erase up
  always_ff @(posedge clk) begin
    if (sys_rst) erased_r <= 1'b0;
    else if (erase_go) erased_r <= 1'b1;
    else if (prog_go && ptr_r == USER_CNT - 16'h0001) erased_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Word port: read side

  assign word_count = ro_mode ? FULL_CNT : USER_CNT;
  assign rd_idx = ptr_r - 16'h0002;
  assign mfr_word = `EBA_MFR_FILL ^ (rd_idx - USER_CNT);

  always_comb begin
    rd_word = 16'h0000;
    rd_over = 1'b0;
    if (mode_w == EBA_LOCKED || dir_r == DIR_WRITE) begin
      rd_word = 16'h0000;
    end else if (ptr_r == 16'h0000) begin
      rd_word = `EBA_PACK_REV_ID;
    end else if (ptr_r == 16'h0001) begin
      rd_word = word_count;
    end else if (rd_idx < word_count) begin
      rd_word = (rd_idx < USER_CNT) ? nvm_word : mfr_word;
    end else begin
      rd_over = 1'b1;
    end
  end

  // Mixing directions in one session is a host fault; locking keeps
  // a half-written store from being read back as if it were good
  assign rd_lock = (mode_w != EBA_LOCKED) &&
    (dir_r == DIR_WRITE || rd_over);
  assign rd_adv = dat_rd && (mode_w != EBA_LOCKED) && !rd_lock;

  ////////////////////////////////////////////////////////////////////////
  // Word port: write side

  always_comb begin
    wr_lock = 1'b0;
    prog_go = 1'b0;
    if (!dat_wr || mode_w == EBA_LOCKED) begin
      wr_lock = 1'b0;
    end else if (ro_mode) begin
      wr_lock = 1'b1;
    end else if (!erased_r || dir_r == DIR_READ) begin
      wr_lock = 1'b1;
    end else if (ptr_r >= USER_CNT) begin
      wr_lock = 1'b1;
    end else begin
      prog_go = 1'b1;
    end
  end

  assign lock_req = (dat_rd && rd_lock) || wr_lock || ers_lock;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and session direction

  always_ff @(posedge clk) begin
    if (sys_rst) ptr_r <= `EBA_PTR_RST;
    else if (seq_done || erase_go) ptr_r <= `EBA_PTR_RST;
    else if (rd_adv || prog_go) ptr_r <= ptr_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) dir_r <= DIR_NONE;
    else if (seq_done || erase_go || lock_req) dir_r <= DIR_NONE;
    else if (rd_adv) dir_r <= DIR_READ;
    else if (prog_go) dir_r <= DIR_WRITE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Store

  // The store is the only place written words go: nothing here
  // reaches the working configuration
  eba_nvm #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nvm (
    .clk(clk),
    .sys_rst(sys_rst),
    .erase_go(erase_go),
    .prog_go(prog_go),
    .prog_addr(ptr_r[`EBA_ADDR_W-1:0]),
    .prog_data(cmd.wdata),
    .rd_addr(rd_idx[`EBA_ADDR_W-1:0]),
    .rd_data(nvm_word),
    .busy(nvm_busy)
  );

  assign busy = nvm_busy;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`EBA_STAT_NOTBUSY_BIT] = !nvm_busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer

  always_comb begin
    ans_data = 16'h0000;
    if (cmd.write) ans_data = 16'h0000;
    else if (is_stat) ans_data = {8'h00, status_byte};
    else if (is_key) ans_data = (mode_w == EBA_LOCKED) ? 16'h0000 :
      {8'h00, last_key_r};
    else if (is_erase) ans_data = {8'h00, ers_val_r};
    else if (is_data) ans_data = rd_word;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rsp_valid_r <= 1'b0;
    else rsp_valid_r <= cmd_valid;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else if (cmd_valid) begin
      rsp_r.nack <= refuse;
      rsp_r.data <= refuse ? 16'h0000 : ans_data;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_PTR_RESET: assert property (seq_done |=>
    ptr_r == 16'h0000 && dir_r == DIR_NONE)
    else $error("unlock did not clear the pointer");
  AST_STAT_ACK: assert property (cmd_valid && is_stat |=>
    rsp_valid && !rsp.nack && rsp.data[7:0] == $past(status_byte))
    else $error("status read refused");
  AST_BUSY_NACK: assert property (cmd_valid && nvm_busy &&
    !is_stat |=> rsp_valid && rsp.nack)
    else $error("command taken while busy");
  AST_ERASE_BUSY: assert property (erase_go |=>
    (!status_byte[`EBA_STAT_NOTBUSY_BIT])[*8])
    else $error("not-busy flag set during erase");
  AST_KEY_LOCKED: assert property (cmd_valid && is_key &&
    !cmd.write && mode_w == EBA_LOCKED |=> rsp.data == 16'h0000)
    else $error("locked key read not zero");
  AST_FIRST_ID: assert property (dat_rd && rd_adv &&
    ptr_r == 16'h0000 |=> rsp.data == `EBA_PACK_REV_ID && ptr_r == 1)
    else $error("first read not packing id");
  AST_COUNT: assert property (rd_adv && ptr_r == 16'h0001 &&
    ro_mode |=> rsp.data == FULL_CNT)
    else $error("word count wrong");
  AST_OVER_READ: assert property (dat_rd && rd_over &&
    mode_w != EBA_LOCKED |=> rsp.data == 16'h0000 &&
    mode_w == EBA_LOCKED) else $error("overrun read did not lock");
  AST_FULL_LOCK: assert property (dat_wr && rw_mode &&
    ptr_r >= USER_CNT |=> mode_w == EBA_LOCKED && !nvm_busy)
    else $error("overflow write did not lock");
  AST_BAD_ERASE: assert property (ers_wr && rw_mode &&
    cmd.wdata[7:0] != `EBA_ERASE_KEY |=> mode_w == EBA_LOCKED)
    else $error("bad erase value did not lock");
  AST_RO_WRITE: assert property (dat_wr && ro_mode |=>
    mode_w == EBA_LOCKED && !nvm_busy)
    else $error("read-only mode took a write");
  AST_PEC_REQ: assert property (cmd_valid && ours && cmd.write &&
    req_pec && !cmd.pec_present |=> rsp.nack)
    else $error("missing pec accepted in strict mode");
  AST_RO_ERASE: assert property (ers_wr && ro_mode |=>
    mode_w == EBA_LOCKED && !nvm_busy)
    else $error("read-only mode took an erase");
  AST_COUNT_RW: assert property (rd_adv && ptr_r == 16'h0001 &&
    rw_mode |=> rsp.data == USER_CNT)
    else $error("user word count wrong");
  AST_KEY_BACK: assert property (cmd_valid && is_key && !cmd.write &&
    mode_w != EBA_LOCKED && !nvm_busy |=>
    rsp.data == {8'h00, $past(last_key_r)})
    else $error("key readback not last byte");
  AST_ERASE_BACK: assert property (cmd_valid && is_erase &&
    !cmd.write && !nvm_busy |=> rsp.data == {8'h00, $past(ers_val_r)})
    else $error("erase readback not last value");
  AST_READ_ADV: assert property (rd_adv |=>
    ptr_r == $past(ptr_r) + 16'h0001)
    else $error("read did not advance pointer");
  AST_PROG_ADV: assert property (prog_go |=>
    ptr_r == $past(ptr_r) + 16'h0001 && nvm_busy)
    else $error("write did not advance and program");
  AST_LOCKED_WRITE: assert property (dat_wr &&
    mode_w == EBA_LOCKED |=> !nvm_busy)
    else $error("locked part programmed a word");
  AST_REFUSE_KEEP: assert property (cmd_valid && refuse |=>
    mode_w == $past(mode_w) && ptr_r == $past(ptr_r))
    else $error("refused command had an effect");
  AST_ERASE_START: assert property (erase_go |=>
    nvm_busy && ptr_r == 16'h0000)
    else $error("erase did not start");

endmodule : eba_bulk_access

/* logic/eba_map.svh */
/*
  Command codes, key bytes, field positions, reset values and timing
  counts of the bulk programming gate. Assumes a 10 MHz core clock.
*/
`ifndef EBA_MAP_SVH
`define EBA_MAP_SVH
`define EBA_CMD_UNLOCK 8'hBD
`define EBA_CMD_ERASE 8'hBE
`define EBA_CMD_DATA 8'hBF
`define EBA_CMD_STATUS 8'hEF
`define EBA_KEY_LEAD 8'h2B
`define EBA_KEY_RW_OPT 8'hD4
`define EBA_KEY_RW_REQ 8'hD5
`define EBA_KEY_RO_MID 8'h91
`define EBA_KEY_RO_OPT 8'hE4
`define EBA_KEY_RO_REQ 8'hE5
`define EBA_ERASE_KEY 8'h2B
// Arbitrary value
`define EBA_PACK_REV_ID 16'h0001
`define EBA_USER_WORDS 64
`define EBA_MFR_WORDS 8
`define EBA_ADDR_W 6
`define EBA_MFR_FILL 16'hA500
`define EBA_ERASED_WORD 16'hFFFF
`define EBA_STAT_NOTBUSY_BIT 6
`define EBA_BYTE_RST 8'h00
`define EBA_PTR_RST 16'h0000
`define EBA_CLK_HZ 10000000
`define EBA_ERASE_TIME_MS 400
`define EBA_PROG_TIME_MS 0.51
`define EBA_ERASE_CYC (`EBA_ERASE_TIME_MS * (`EBA_CLK_HZ / 1000))
`define EBA_PROG_CYC \
  ($rtoi(`EBA_PROG_TIME_MS * `EBA_CLK_HZ / 1000.0 + 0.999))
`endif

/* logic/eba_pkg.sv */
/*
  Types of the bulk programming gate: modes, sequencer stages and the
  command and answer carriers. Assumes nothing else.
*/
package eba_pkg;
  typedef enum logic [2:0] {
    EBA_LOCKED, EBA_RW_OPT, EBA_RW_REQ, EBA_RO_OPT, EBA_RO_REQ
  } eba_mode_t;
  typedef enum logic [1:0] {STG_IDLE, STG_LEAD, STG_MID} eba_stage_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_READ, DIR_WRITE} eba_dir_t;
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
    logic pec_present;
    logic pec_ok;
  } eba_cmd_t;
  typedef struct packed {
    logic nack;
    logic [15:0] data;
  } eba_rsp_t;
endpackage : eba_pkg

/* logic/eba_unlock.sv */
/*
  Key sequencer: recognises the four unlock sequences and holds the
  access mode. Assumes key writes come one per accepted command.
*/
`timescale 1ns/1ps
`include "eba_map.svh"
module eba_unlock
  import eba_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic key_wr, // Accepted key byte write
  input wire logic [7:0] key_byte, // Key byte
  input wire logic lock_req, // Force locked
  output eba_mode_t mode, // Current access mode
  output logic seq_done // Sequence completed now
);
  eba_stage_t stage_r, stage_nxt;
  eba_mode_t mode_r, mode_nxt;

  always_comb begin
    stage_nxt = stage_r;
    mode_nxt = mode_r;
    seq_done = 1'b0;
    if (key_wr) begin
      stage_nxt = STG_IDLE;
      mode_nxt = EBA_LOCKED;
      case (stage_r)
        STG_IDLE: begin
          if (key_byte == `EBA_KEY_LEAD) stage_nxt = STG_LEAD;
        end
        STG_LEAD: begin
          if (key_byte == `EBA_KEY_RW_OPT) mode_nxt = EBA_RW_OPT;
          else if (key_byte == `EBA_KEY_RW_REQ) mode_nxt = EBA_RW_REQ;
          else if (key_byte == `EBA_KEY_RO_MID) stage_nxt = STG_MID;
        end
        STG_MID: begin
          if (key_byte == `EBA_KEY_RO_OPT) mode_nxt = EBA_RO_OPT;
          else if (key_byte == `EBA_KEY_RO_REQ) mode_nxt = EBA_RO_REQ;
        end
        default: stage_nxt = STG_IDLE;
      endcase
      seq_done = (mode_nxt != EBA_LOCKED);
    end else if (lock_req) begin
      mode_nxt = EBA_LOCKED;
      stage_nxt = STG_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) stage_r <= STG_IDLE;
    else stage_r <= stage_nxt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) mode_r <= EBA_LOCKED;
    else mode_r <= mode_nxt;
  end

  assign mode = mode_r;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RW_OPT: assert property (key_wr && stage_r == STG_LEAD &&
    key_byte == `EBA_KEY_RW_OPT |=> mode_r == EBA_RW_OPT)
    else $error("rw pec-optional key not taken");
  AST_RW_REQ: assert property (key_wr && stage_r == STG_LEAD &&
    key_byte == `EBA_KEY_RW_REQ |=> mode_r == EBA_RW_REQ)
    else $error("rw pec-required key not taken");
  AST_RO_OPT: assert property (key_wr && stage_r == STG_MID &&
    key_byte == `EBA_KEY_RO_OPT |=> mode_r == EBA_RO_OPT)
    else $error("ro pec-optional key not taken");
  AST_RO_REQ: assert property (key_wr && stage_r == STG_MID &&
    key_byte == `EBA_KEY_RO_REQ |=> mode_r == EBA_RO_REQ)
    else $error("ro pec-required key not taken");
  AST_BAD_SEQ: assert property (key_wr && !seq_done |=>
    mode_r == EBA_LOCKED) else $error("bad key left part unlocked");
endmodule : eba_unlock

/* logic/eba_nvm.sv */
/*
  Nonvolatile word store with bulk erase and word program timers.
  Assumes starts are only issued while busy is low.
*/
`timescale 1ns/1ps
`include "eba_map.svh"
module eba_nvm
  import eba_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `EBA_ERASE_CYC,
  parameter int unsigned PROG_CYCLES = `EBA_PROG_CYC
) (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic erase_go, // Start bulk erase
  input wire logic prog_go, // Start word program
  input wire logic [`EBA_ADDR_W-1:0] prog_addr, // Word to program
  input wire logic [15:0] prog_data, // Value to program
  input wire logic [`EBA_ADDR_W-1:0] rd_addr, // Word to read
  output logic [15:0] rd_data, // Stored word
  output logic busy // Operation running
);
  logic [21:0] timer_r, len_r;
  logic busy_r, op_erase_r, commit;
  logic [`EBA_ADDR_W-1:0] addr_r;
  logic [15:0] data_r;
  // Contents survive reset on purpose: this models the cell array
  logic [15:0] mem_r [`EBA_USER_WORDS];

  assign commit = busy_r && (timer_r == 22'h00_0000);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      timer_r <= 22'h00_0000;
    end else if (!busy_r && (erase_go || prog_go)) begin
      busy_r <= 1'b1;
      timer_r <= erase_go ? 22'(ERASE_CYCLES - 1)
                          : 22'(PROG_CYCLES - 1);
    end else if (commit) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      timer_r <= timer_r - 22'h00_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_erase_r <= 1'b0;
      addr_r <= '0;
      data_r <= 16'h0000;
    end else if (!busy_r && (erase_go || prog_go)) begin
      op_erase_r <= erase_go;
      addr_r <= prog_addr;
      data_r <= prog_data;
    end
  end

  // Cells change only when the operation time has run out
  for (genvar i = 0; i < `EBA_USER_WORDS; i++) begin : g_word
    localparam logic [`EBA_ADDR_W-1:0] IDX = `EBA_ADDR_W'(i);
    always_ff @(posedge clk) begin
      if (commit && op_erase_r) mem_r[i] <= `EBA_ERASED_WORD;
      else if (commit && addr_r == IDX) mem_r[i] <= data_r;
    end
  end

  assign rd_data = mem_r[rd_addr];
  assign busy = busy_r;

  always_ff @(posedge clk) begin
    if (sys_rst || !busy_r) len_r <= 22'h00_0000;
    else len_r <= len_r + 22'h00_0001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_ERASE_LEN: assert property (commit && op_erase_r |->
    len_r == 22'(ERASE_CYCLES - 1)) else $error("erase busy length wrong");
endmodule : eba_nvm

/* test/eba_host_model.sv */
/*
  Host side of the command port: issues one decoded command at a time
  and polls the status byte. Assumes callers start just after a rising
  edge of clk.
*/
`timescale 1ns/1ps
`include "eba_map.svh"
module eba_host_model
  import eba_pkg::*;
(
  input wire logic clk, // Core clock
  output logic cmd_valid, // Command strobe
  output eba_cmd_t cmd, // Command toward the gate
  input wire logic rsp_valid, // Answer strobe
  input wire eba_rsp_t rsp // Answer
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  //////////////////////////////////////////////////////////////////////
  // Only codes 0xBD, 0xBE, 0xBF and status are used; the caller never
  // mixes word reads and writes within one session
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] wd, input logic pec, output eba_rsp_t r);
    cmd_valid = 1'b1;
    cmd = '{write: wr, code: code, wdata: wd, pec_present: pec,
      pec_ok: pec};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // A released bus must not keep showing the last command
    cmd = ~cmd;
    r = rsp_valid ? rsp : 17'h1_dead;
    // One idle edge, so the next call never raises the strobe in the
    // same time step in which this one lowered it
    @(posedge clk);
    #1;
  endtask : xfer

  // Status polling instead of fixed waits keeps word spacing safe
  task automatic wait_idle(output int n);
    eba_rsp_t s;
    n = 0;
    do begin
      xfer(1'b0, `EBA_CMD_STATUS, 16'h0000, 1'b0, s);
      n++;
    end while (s !== 17'h0_0040 && n < 1000);
  endtask : wait_idle
endmodule : eba_host_model

/* test/eba_bulk_access_tb.sv */
/*
  Self-checking bench of the bulk programming gate: key table, erase,
  write and read passes, refusals and reset. Assumes shortened erase
  and program counts.
*/
`timescale 1ns/1ps
`include "eba_map.svh"
module eba_bulk_access_tb;
  import eba_pkg::*;
  localparam int ERASE_N = 40;
  // Each status poll spans two clocks, so erase polls run half as many
  localparam int POLL_N = ERASE_N / 2;
  typedef struct {
    logic [7:0] k0, k1, k2;
    int len;
    eba_mode_t m;
    logic [7:0] back;
    logic preq;
  } eba_row_t;
  logic clk, sys_rst, cmd_valid, rsp_valid, pec_required, busy;
  logic [7:0] status_byte;
  eba_cmd_t cmd;
  eba_rsp_t rsp, r;
  eba_mode_t mode;
  int err_total, checks, cycles, n;
  eba_row_t rows [7] = '{
    '{8'h2b, 8'hd4, 8'h00, 2, EBA_RW_OPT, 8'hd4, 1'b0},
    '{8'h2b, 8'hd5, 8'h00, 2, EBA_RW_REQ, 8'hd5, 1'b1},
    '{8'h2b, 8'h91, 8'he4, 3, EBA_RO_OPT, 8'he4, 1'b0},
    '{8'h2b, 8'h91, 8'he5, 3, EBA_RO_REQ, 8'he5, 1'b1},
    '{8'h2b, 8'h55, 8'h00, 2, EBA_LOCKED, 8'h00, 1'b0},
    '{8'h2b, 8'h91, 8'hd4, 3, EBA_LOCKED, 8'h00, 1'b0},
    '{8'h2b, 8'h00, 8'h00, 1, EBA_LOCKED, 8'h00, 1'b0}
  };

  eba_bulk_access #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(8)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .pec_required(pec_required),
    .status_byte(status_byte), .mode(mode), .busy(busy));
  eba_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp));

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_mode(input eba_mode_t exp);
    cmp({14'h0000, mode}, {14'h0000, exp});
  endtask : cmp_mode

  // Keys always carry a good PEC so they pass in every mode
  task automatic unlock(input logic [7:0] k0, k1, k2, input int len);
    logic [7:0] k [3];
    k = '{k0, k1, k2};
    for (int i = 0; i < len; i++) begin
      i_host.xfer(1'b1, `EBA_CMD_UNLOCK, {8'h00, k[i]}, 1'b1, r);
    end
  endtask : unlock

  // Id, count, then words; one read past the end
  task automatic read_pass(input int words);
    logic [15:0] e;
    for (int i = 0; i < words + 3; i++) begin
      i_host.xfer(1'b0, `EBA_CMD_DATA, 16'h0000, 1'b0, r);
      if (i == 0) e = `EBA_PACK_REV_ID;
      else if (i == 1) e = 16'(words);
      else if (i == words + 2) e = 16'h0000;
      else if (i < 66) e = 16'h1000 + 16'(i - 2);
      else e = `EBA_MFR_FILL ^ 16'(i - 66);
      cmp(r, {1'b0, e});
    end
    cmp_mode(EBA_LOCKED);
  endtask : read_pass

  task automatic stop_test();
    $display("counts: checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks = 0;
    cycles = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    cmp_mode(EBA_LOCKED);
    cmp({9'h000, status_byte}, 17'h0_0040);
    foreach (rows[i]) begin
      unlock(rows[i].k0, rows[i].k1, rows[i].k2, rows[i].len);
      cmp_mode(rows[i].m);
      cmp({16'h0000, pec_required}, {16'h0000, rows[i].preq});
      i_host.xfer(1'b0, `EBA_CMD_UNLOCK, 16'h0000, 1'b1, r);
      cmp(r, {9'h000, rows[i].back});
    end
    // The last row leaves a lone lead byte pending; a stray byte drops it
    unlock(8'h00, 8'h00, 8'h00, 1);
    cmp_mode(EBA_LOCKED);
    $display("test key table done");
    unlock(8'h2b, 8'hd5, 8'h00, 2);
    i_host.xfer(1'b1, `EBA_CMD_DATA, 16'h1234, 1'b0, r);
    cmp(r, 17'h1_0000);
    unlock(8'h2b, 8'hd4, 8'h00, 2);
    i_host.xfer(1'b1, `EBA_CMD_ERASE, 16'h002b, 1'b0, r);
    cmp(r, 17'h0_0000);
    cmp({16'h0000, busy}, 17'h0_0001);
    i_host.xfer(1'b0, `EBA_CMD_UNLOCK, 16'h0000, 1'b0, r);
    cmp(r, 17'h1_0000);
    i_host.xfer(1'b0, `EBA_CMD_STATUS, 16'h0000, 1'b0, r);
    cmp(r, 17'h0_0000);
    i_host.wait_idle(n);
    cmp({16'h0000, n >= POLL_N - 4 && n <= POLL_N}, 17'h0_0001);
    cmp({16'h0000, busy}, 17'h0_0000);
    i_host.xfer(1'b0, `EBA_CMD_ERASE, 16'h0000, 1'b0, r);
    cmp(r, 17'h0_002b);
    $display("test erase done");
    // Re-unlocking after erase restarts the pointer at word zero
    unlock(8'h2b, 8'hd4, 8'h00, 2);
    for (int i = 0; i < 64; i++) begin
      i_host.xfer(1'b1, `EBA_CMD_DATA, 16'h1000 + 16'(i), 1'b0, r);
      cmp(r, 17'h0_0000);
      i_host.wait_idle(n);
    end
    cmp_mode(EBA_RW_OPT);
    i_host.xfer(1'b1, `EBA_CMD_DATA, 16'h5555, 1'b0, r);
    cmp_mode(EBA_LOCKED);
    i_host.xfer(1'b1, `EBA_CMD_DATA, 16'h5555, 1'b0, r);
    cmp({16'h0000, busy}, 17'h0_0000);
    $display("test write pass done");
    unlock(8'h2b, 8'hd4, 8'h00, 2);
    repeat (3) i_host.xfer(1'b0, `EBA_CMD_DATA, 16'h0000, 1'b0, r);
    unlock(8'h2b, 8'hd5, 8'h00, 2);
    read_pass(64);
    unlock(8'h2b, 8'h91, 8'he4, 3);
    read_pass(72);
    $display("test read passes done");
    unlock(8'h2b, 8'h91, 8'he4, 3);
    i_host.xfer(1'b1, `EBA_CMD_DATA, 16'h0001, 1'b0, r);
    cmp_mode(EBA_LOCKED);
    unlock(8'h2b, 8'h91, 8'he5, 3);
    i_host.xfer(1'b1, `EBA_CMD_ERASE, 16'h002b, 1'b1, r);
    cmp_mode(EBA_LOCKED);
    unlock(8'h2b, 8'hd4, 8'h00, 2);
    i_host.xfer(1'b1, `EBA_CMD_ERASE, 16'h0055, 1'b0, r);
    cmp_mode(EBA_LOCKED);
    i_host.xfer(1'b0, `EBA_CMD_ERASE, 16'h0000, 1'b0, r);
    cmp(r, 17'h0_0055);
    $display("test refusals done");
    unlock(8'h2b, 8'hd4, 8'h00, 2);
    sys_rst = 1'b1;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    cmp_mode(EBA_LOCKED);
    i_host.xfer(1'b0, `EBA_CMD_UNLOCK, 16'h0000, 1'b0, r);
    cmp(r, 17'h0_0000);
    $display("test reset done");
    stop_test();
  end
endmodule : eba_bulk_access_tb
